// ### rtl/dbm_pkg.sv
// package of shared constants and types for the dma bus-master signalling block
// assumes a single 100 MHz clock and an active-low asynchronous reset
package dbm_pkg;

  localparam int unsigned NUM_CH      = 4;
  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned LOW_W       = 4;
  localparam int unsigned MID_W       = 4;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned LOW_LSB     = 0;
  localparam int unsigned MID_LSB     = 4;
  localparam int unsigned UPPER_LSB   = 8;
  localparam int unsigned SYNC_STAGES = 2;

  // reset values and the low-byte rollover value
  localparam logic              GRANT_POL_RESET  = 1'b0;
  localparam logic [ADDR_W-1:0] ADDR_RESET       = 16'h0000;
  localparam logic [ADDR_W-1:0] COUNT_RESET      = 16'h0000;
  localparam logic [7:0]        LOW_BYTE_ROLL    = 8'hFF;
  localparam logic [1:0]        CHAN_RESET       = 2'h0;

  typedef enum logic [1:0] {
    DBM_XFER_VERIFY,
    DBM_XFER_WRITE,
    DBM_XFER_READ,
    DBM_XFER_MEM2MEM
  } dbm_xfer_t;

  typedef enum {
    DBM_ST_IDLE,
    DBM_ST_HOLD_WAIT,
    DBM_ST_ADDR_UPDATE,
    DBM_ST_CMD,
    DBM_ST_XFER,
    DBM_ST_END
  } dbm_state_t;

endpackage : dbm_pkg

// ### rtl/dbm_strobe_if.sv
// interface between the sequencer and the falling-edge address strobe generator
// assumes both ends share clk_in
`timescale 1ns/1ps
`default_nettype none
interface dbm_strobe_if;
  logic strobe_req;
  logic strobe;

  modport seq (output strobe_req, input strobe);
  modport gen (input strobe_req, output strobe);
endinterface : dbm_strobe_if
`default_nettype wire

// ### rtl/dbm_strobe_gen.sv
// falling-edge generator of the upper-address strobe
// assumes strobe_req is a posedge-clocked level from the sequencer
`timescale 1ns/1ps
`default_nettype none
module dbm_strobe_gen (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  dbm_strobe_if.gen strobe_if
);

  logic strobe_reg;

  // ----------------------------------------
  // falling-edge strobe
  // ----------------------------------------
  // half-cycle offset lets the latch open after the byte settles on the data bus
  always_ff @(negedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strobe_reg <= 1'b0;
    end else begin
      strobe_reg <= strobe_if.strobe_req; // R12
    end
  end

  assign strobe_if.strobe = strobe_reg;

  strobe_follows_a: assert property ( // R12
    @(negedge clk_in) disable iff (!reset_n_in)
    strobe_if.strobe_req |=> strobe_reg)
    else $error("address strobe missed its request");

endmodule : dbm_strobe_gen
`default_nettype wire

// ### rtl/dbm_bus_master.sv
// dma bus-master signalling: hold handshake, address lines, strobes, grants
// assumes descriptor, mask and software request inputs come from same-clock logic
//
// Function
// [R1] while idle the low address lines are inputs that select an internal register
// [R2] during service the low address lines drive the low four address bits
// [R3] the middle address lines are driven only during service, high impedance otherwise
// [R4] hold request rises on an unmasked channel request or a software request
// [R5] the host grants the bus and the buses are not driven before that grant
// [R6] with hold request looped to hold grant exactly one hold-wait state is spent
// [R7] the selected channel's grant output tells the peripheral it owns the cycle
// [R8] grant polarity is programmable and is active low after reset
// [R9] the upper-address enable is high during transfers
// [R10] the upper-address strobe pulses so an external latch captures the upper byte
// [R11] in block mode the address-update state and strobe occur only when the upper byte changes; memory-to-memory still enters it before each write half
// [R12] the upper-address strobe is timed from the falling clock edge
// [R13] the memory read strobe is driven low in read and memory-to-memory transfers
// [R14] the memory write strobe is driven low in write and memory-to-memory transfers
// [R15] a peripheral holds its request until its grant goes active
// [R16] during the address-update state the upper address byte is driven on the data bus
// [R17] while inactive all address and control outputs are high impedance; the enable, upper strobe, grants and hold request stay driven, grants inactive
`timescale 1ns/1ps
`default_nettype none
module dbm_bus_master (
  input  wire logic                           clk_in,
  input  wire logic                           reset_n_in,
  input  wire logic [dbm_pkg::NUM_CH-1:0]     channel_service_request_in,
  input  wire logic [dbm_pkg::NUM_CH-1:0]     channel_mask_in,
  input  wire logic [dbm_pkg::NUM_CH-1:0]     software_request_in,
  input  wire logic                           grant_polarity_write_in,
  input  wire logic                           grant_polarity_high_in,
  input  wire logic [dbm_pkg::ADDR_W-1:0]     start_address_in,
  input  wire logic [dbm_pkg::ADDR_W-1:0]     transfer_count_in,
  input  wire logic [1:0]                     transfer_type_in,
  input  wire logic                           block_mode_in,
  input  wire logic                           bus_hold_grant_in,
  input  wire logic [dbm_pkg::LOW_W-1:0]      low_address_lines_in,
  output logic      [dbm_pkg::LOW_W-1:0]      low_address_lines_out,
  output logic                                low_address_lines_oe_n_out,
  output logic      [dbm_pkg::LOW_W-1:0]      register_select_out,
  output logic      [dbm_pkg::MID_W-1:0]      middle_address_lines_out,
  output logic                                middle_address_lines_oe_n_out,
  output logic      [dbm_pkg::DATA_W-1:0]     data_bus_lines_out,
  output logic                                data_bus_lines_oe_n_out,
  output logic                                bus_hold_request_out,
  output logic      [dbm_pkg::NUM_CH-1:0]     channel_service_grant_out,
  output logic                                upper_address_enable_out,
  output logic                                upper_address_strobe_out,
  output logic                                memory_read_strobe_out,
  output logic                                memory_write_strobe_out,
  output logic                                memory_strobes_oe_n_out,
  output logic                                service_done_out
);

  dbm_pkg::dbm_state_t                     state_reg;
  dbm_pkg::dbm_state_t                     state_next;
  dbm_pkg::dbm_xfer_t                      type_reg;
  logic [dbm_pkg::NUM_CH-1:0]              req_sync1_reg;
  logic [dbm_pkg::NUM_CH-1:0]              req_sync2_reg;
  logic [dbm_pkg::LOW_W-1:0]               sel_sync1_reg;
  logic [dbm_pkg::LOW_W-1:0]               sel_sync2_reg;
  logic [dbm_pkg::NUM_CH-1:0]              pending;
  logic [dbm_pkg::NUM_CH-1:0]              chan_onehot;
  logic [1:0]                              chan_pick;
  logic [1:0]                              chan_reg;
  logic [dbm_pkg::ADDR_W-1:0]              addr_reg;
  logic [dbm_pkg::ADDR_W-1:0]              count_reg;
  logic                                    block_reg;
  logic                                    phase_reg;
  logic                                    hold_req_reg;
  logic                                    grant_pol_reg;
  logic                                    done_reg;
  logic                                    working;
  logic                                    last_xfer;
  logic                                    upper_change;
  dbm_strobe_if strobe_if ();

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      req_sync1_reg <= '0;
      req_sync2_reg <= '0;
      sel_sync1_reg <= '0;
      sel_sync2_reg <= '0;
    end else begin
      req_sync1_reg <= channel_service_request_in;
      req_sync2_reg <= req_sync1_reg;
      sel_sync1_reg <= low_address_lines_in;
      sel_sync2_reg <= sel_sync1_reg;
    end
  end

  assign register_select_out = sel_sync2_reg; // R1

  // ----------------------------------------
  // channel selection
  // ----------------------------------------
  // requests are levels; the peripheral keeps its request up until granted
  assign pending = (req_sync2_reg & ~channel_mask_in) | software_request_in; // R4 R15
  // fixed priority, channel 0 highest
  always_comb begin
    chan_pick = dbm_pkg::CHAN_RESET;
    for (int i = dbm_pkg::NUM_CH - 1; i >= 0; i--) begin
      if (pending[i]) begin
        chan_pick = 2'(i);
      end
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  assign last_xfer    = (count_reg == dbm_pkg::COUNT_RESET);
  assign upper_change = (addr_reg[7:0] == dbm_pkg::LOW_BYTE_ROLL);
  assign working      = (state_reg != dbm_pkg::DBM_ST_IDLE) &&
                        (state_reg != dbm_pkg::DBM_ST_HOLD_WAIT);
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      dbm_pkg::DBM_ST_IDLE: begin
        if (pending != '0) begin
          state_next = dbm_pkg::DBM_ST_HOLD_WAIT; // R4
        end
      end
      dbm_pkg::DBM_ST_HOLD_WAIT: begin
        if (bus_hold_grant_in) begin
          state_next = dbm_pkg::DBM_ST_ADDR_UPDATE; // R5 R6
        end
      end
      dbm_pkg::DBM_ST_ADDR_UPDATE: begin
        state_next = dbm_pkg::DBM_ST_CMD;
      end
      dbm_pkg::DBM_ST_CMD: begin
        state_next = dbm_pkg::DBM_ST_XFER;
      end
      dbm_pkg::DBM_ST_XFER: begin
        state_next = dbm_pkg::DBM_ST_END;
      end
      dbm_pkg::DBM_ST_END: begin
        if (type_reg == dbm_pkg::DBM_XFER_MEM2MEM && !phase_reg) begin
          state_next = dbm_pkg::DBM_ST_ADDR_UPDATE;
        end else if (!block_reg || last_xfer) begin
          state_next = dbm_pkg::DBM_ST_IDLE;
        end else if (upper_change) begin
          state_next = dbm_pkg::DBM_ST_ADDR_UPDATE; // R11
        end else begin
          state_next = dbm_pkg::DBM_ST_CMD; // R11
        end
      end
      default: begin
        state_next = dbm_pkg::DBM_ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= dbm_pkg::DBM_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
  // hold request rises on entry to the hold-wait state, drops on return to idle
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hold_req_reg <= 1'b0;
    end else begin
      hold_req_reg <= (state_next != dbm_pkg::DBM_ST_IDLE); // R4
    end
  end

  // ----------------------------------------
  // transfer descriptor
  // ----------------------------------------
  // descriptor is sampled at request time; later input changes do not disturb a service
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      chan_reg  <= dbm_pkg::CHAN_RESET;
      addr_reg  <= dbm_pkg::ADDR_RESET;
      count_reg <= dbm_pkg::COUNT_RESET;
      type_reg  <= dbm_pkg::DBM_XFER_VERIFY;
      block_reg <= 1'b0;
      phase_reg <= 1'b0;
    end else if (state_reg == dbm_pkg::DBM_ST_IDLE && pending != '0) begin
      chan_reg  <= chan_pick;
      addr_reg  <= start_address_in;
      count_reg <= transfer_count_in;
      type_reg  <= dbm_pkg::dbm_xfer_t'(transfer_type_in);
      block_reg <= block_mode_in;
      phase_reg <= 1'b0;
    end else if (state_reg == dbm_pkg::DBM_ST_END) begin
      if (type_reg == dbm_pkg::DBM_XFER_MEM2MEM && !phase_reg) begin
        phase_reg <= 1'b1;
      end else begin
        phase_reg <= 1'b0;
        addr_reg  <= addr_reg + 16'h0001;
        count_reg <= count_reg - 16'h0001;
      end
    end
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (state_reg != dbm_pkg::DBM_ST_IDLE) &&
                  (state_next == dbm_pkg::DBM_ST_IDLE);
    end
  end

  // ----------------------------------------
  // grant polarity
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      grant_pol_reg <= dbm_pkg::GRANT_POL_RESET; // R8
    end else if (grant_polarity_write_in) begin
      grant_pol_reg <= grant_polarity_high_in; // R8
    end
  end

  // ----------------------------------------
  // upper-address strobe
  // ----------------------------------------
  assign strobe_if.strobe_req = (state_reg == dbm_pkg::DBM_ST_ADDR_UPDATE); // R10 R11
  dbm_strobe_gen strobe_gen_u (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .strobe_if  (strobe_if)
  );

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  generate
    for (genvar g = 0; g < dbm_pkg::NUM_CH; g++) begin : g_grant
      assign chan_onehot[g] = working && (chan_reg == 2'(g)); // R7
      assign channel_service_grant_out[g] = grant_pol_reg ? chan_onehot[g]
                                                          : ~chan_onehot[g]; // R8
    end
  endgenerate
  // address, data and memory strobe outputs float until the host has granted the bus
  assign low_address_lines_out         = addr_reg[dbm_pkg::LOW_LSB +: dbm_pkg::LOW_W]; // R2
  assign low_address_lines_oe_n_out    = ~working; // R1 R2 R5 R17
  assign middle_address_lines_out      = addr_reg[dbm_pkg::MID_LSB +: dbm_pkg::MID_W];
  assign middle_address_lines_oe_n_out = ~working; // R3 R17
  assign data_bus_lines_out            = addr_reg[dbm_pkg::UPPER_LSB +: dbm_pkg::DATA_W]; // R16
  assign data_bus_lines_oe_n_out       = (state_reg != dbm_pkg::DBM_ST_ADDR_UPDATE); // R16
  assign bus_hold_request_out          = hold_req_reg;
  assign upper_address_enable_out      = working; // R9
  assign upper_address_strobe_out      = strobe_if.strobe;
  assign memory_strobes_oe_n_out       = ~working; // R17
  always_comb begin
    memory_read_strobe_out  = 1'b1;
    memory_write_strobe_out = 1'b1;
    if (state_reg == dbm_pkg::DBM_ST_CMD || state_reg == dbm_pkg::DBM_ST_XFER) begin
      if (type_reg == dbm_pkg::DBM_XFER_READ ||
          (type_reg == dbm_pkg::DBM_XFER_MEM2MEM && !phase_reg)) begin
        memory_read_strobe_out = 1'b0; // R13
      end
    end
    // write strobe is narrower, leaving data a cycle to settle
    if (state_reg == dbm_pkg::DBM_ST_XFER) begin
      if (type_reg == dbm_pkg::DBM_XFER_WRITE ||
          (type_reg == dbm_pkg::DBM_XFER_MEM2MEM && phase_reg)) begin
        memory_write_strobe_out = 1'b0; // R14
      end
    end
  end
  assign service_done_out = done_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence idle_with_request_s;
    (state_reg == dbm_pkg::DBM_ST_IDLE) && (pending != '0);
  endsequence
  sequence granted_wait_s;
    (state_reg == dbm_pkg::DBM_ST_HOLD_WAIT) && bus_hold_grant_in;
  endsequence
  sequence block_no_carry_s;
    (state_reg == dbm_pkg::DBM_ST_END) && block_reg && !last_xfer && !upper_change &&
    (type_reg != dbm_pkg::DBM_XFER_MEM2MEM);
  endsequence
  hold_request_rise_a: assert property ( // R4
    @(posedge clk_in) disable iff (!reset_n_in)
    idle_with_request_s |=> bus_hold_request_out && !working)
    else $error("hold request not raised for a pending request");
  single_hold_wait_a: assert property ( // R6
    @(posedge clk_in) disable iff (!reset_n_in)
    granted_wait_s |=> (state_reg == dbm_pkg::DBM_ST_ADDR_UPDATE) ##1
                       (state_reg == dbm_pkg::DBM_ST_CMD))
    else $error("more than one hold-wait state after grant");
  no_drive_ungranted_a: assert property ( // R5
    @(posedge clk_in) disable iff (!reset_n_in)
    (state_reg == dbm_pkg::DBM_ST_HOLD_WAIT) && !bus_hold_grant_in |=>
      middle_address_lines_oe_n_out && low_address_lines_oe_n_out)
    else $error("buses driven before hold grant");
  idle_float_a: assert property ( // R17
    @(posedge clk_in) disable iff (!reset_n_in)
    (state_reg == dbm_pkg::DBM_ST_IDLE) |-> memory_strobes_oe_n_out &&
      data_bus_lines_oe_n_out && !upper_address_enable_out &&
      channel_service_grant_out == {dbm_pkg::NUM_CH{~grant_pol_reg}})
    else $error("outputs driven or grant active while idle");
  low_address_drive_a: assert property ( // R2
    @(posedge clk_in) disable iff (!reset_n_in)
    working |-> !low_address_lines_oe_n_out &&
      low_address_lines_out == addr_reg[3:0] && !channel_service_grant_out[chan_reg] ==
      !grant_pol_reg)
    else $error("low address or grant wrong during service");
  block_skip_update_a: assert property ( // R11
    @(posedge clk_in) disable iff (!reset_n_in)
    block_no_carry_s |=> (state_reg == dbm_pkg::DBM_ST_CMD) && !upper_address_strobe_out)
    else $error("address-update state entered without upper byte change");
  // the falling-edge flop catches the state half a cycle in, so both are seen together
  strobe_in_update_a: assert property ( // R10
    @(posedge clk_in) disable iff (!reset_n_in)
    upper_address_strobe_out == (state_reg == dbm_pkg::DBM_ST_ADDR_UPDATE))
    else $error("upper-address strobe outside address-update state");
  upper_byte_bus_a: assert property ( // R16
    @(posedge clk_in) disable iff (!reset_n_in)
    (state_reg == dbm_pkg::DBM_ST_ADDR_UPDATE) |-> !data_bus_lines_oe_n_out &&
      data_bus_lines_out == addr_reg[15:8] && upper_address_enable_out)
    else $error("upper address byte not on data bus");
  read_strobe_a: assert property ( // R13
    @(posedge clk_in) disable iff (!reset_n_in)
    (state_reg == dbm_pkg::DBM_ST_CMD) && (type_reg == dbm_pkg::DBM_XFER_READ) |->
      !memory_read_strobe_out ##1 !memory_read_strobe_out ##1 memory_read_strobe_out)
    else $error("memory read strobe timing wrong");
  write_strobe_a: assert property ( // R14
    @(posedge clk_in) disable iff (!reset_n_in)
    (state_reg == dbm_pkg::DBM_ST_CMD) && (type_reg == dbm_pkg::DBM_XFER_WRITE) |->
      memory_write_strobe_out ##1 !memory_write_strobe_out ##1 memory_write_strobe_out)
    else $error("memory write strobe timing wrong");

endmodule : dbm_bus_master
`default_nettype wire

// ### sim/dbm_host_model.sv
// host arbiter and peripherals facing the dma bus-master block
// assumes requests and grants are sampled on the rising edge of clk_in
`timescale 1ns/1ps
`default_nettype none
module dbm_host_model (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       bus_hold_request_in,
  input  wire logic [3:0] grant_delay_in,
  output logic            bus_hold_grant_out,
  input  wire logic [3:0] raise_request_in,
  input  wire logic [3:0] channel_service_grant_in,
  input  wire logic       grant_active_high_in,
  output logic      [3:0] channel_service_request_out
);
  logic [3:0] wait_reg;
  logic       slow_grant_reg;
  logic [3:0] active_grants;

  // zero delay is the stand-alone loopback wiring
  assign bus_hold_grant_out = (grant_delay_in == 4'h0) ? bus_hold_request_in : slow_grant_reg;
  assign active_grants = grant_active_high_in ? channel_service_grant_in
                                              : ~channel_service_grant_in;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wait_reg       <= 4'h0;
      slow_grant_reg <= 1'b0;
    end else if (!bus_hold_request_in) begin
      wait_reg       <= 4'h0;
      slow_grant_reg <= 1'b0;
    end else if (wait_reg == grant_delay_in) begin
      slow_grant_reg <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end

  // a peripheral keeps asking until its own grant turns up
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      channel_service_request_out <= 4'h0;
    end else begin
      channel_service_request_out <= (channel_service_request_out | raise_request_in)
                                     & ~active_grants;
    end
  end
endmodule : dbm_host_model
`default_nettype wire

// ### sim/dbm_bus_master_test.sv
// self-checking bench for the dma bus-master signalling block
// assumes the host model answers hold requests and holds peripheral requests
`timescale 1ns/1ps
`default_nettype none
module dbm_bus_master_test;
  logic        clk_in, reset_n_in, pol_write, pol_high, block, grant, hold, en, stb;
  logic        rd_n, wr_n, mem_oe_n, low_oe_n, mid_oe_n, data_oe_n, done, pol_hi;
  logic [3:0]  req, mask, sw, raise, dly, low_in, low_out, sel, mid, gnt;
  logic [15:0] addr, cnt;
  logic [1:0]  ty;
  logic [7:0]  data;
  logic [7:0]  addrs[$];
  logic [7:0]  uppers[$];
  int          num_errors, samples_checked, cycles;

  dbm_bus_master uut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .channel_service_request_in(req), .channel_mask_in(mask), .software_request_in(sw),
    .grant_polarity_write_in(pol_write), .grant_polarity_high_in(pol_high),
    .start_address_in(addr), .transfer_count_in(cnt), .transfer_type_in(ty),
    .block_mode_in(block), .bus_hold_grant_in(grant), .low_address_lines_in(low_in),
    .low_address_lines_out(low_out), .low_address_lines_oe_n_out(low_oe_n),
    .register_select_out(sel), .middle_address_lines_out(mid),
    .middle_address_lines_oe_n_out(mid_oe_n), .data_bus_lines_out(data),
    .data_bus_lines_oe_n_out(data_oe_n), .bus_hold_request_out(hold),
    .channel_service_grant_out(gnt), .upper_address_enable_out(en),
    .upper_address_strobe_out(stb), .memory_read_strobe_out(rd_n),
    .memory_write_strobe_out(wr_n), .memory_strobes_oe_n_out(mem_oe_n),
    .service_done_out(done));

  dbm_host_model host (.clk_in(clk_in), .reset_n_in(reset_n_in), .bus_hold_request_in(hold),
    .grant_delay_in(dly), .bus_hold_grant_out(grant), .raise_request_in(raise),
    .channel_service_grant_in(gnt), .grant_active_high_in(pol_hi),
    .channel_service_request_out(req));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  task automatic idle_check();
    @(posedge clk_in);
    #1;
    chk("idle_oe", 4'hF, {low_oe_n, mid_oe_n, data_oe_n, mem_oe_n});
    chk("idle_ctrl", 16'h0, {hold, en, stb});
    chk("idle_grant", pol_hi ? 4'h0 : 4'hF, gnt);
  endtask : idle_check

  // slow grant only checked for no early drive, loopback for the exact wait
  task automatic service(input logic [1:0] ch, input logic use_sw, input logic [1:0] t,
      input logic b, input logic [15:0] a, input logic [15:0] n, input logic [3:0] d,
      input int e_hw, input int e_stb, input int e_rd, input int e_wr);
    int         hw, ng, st, rc, wc, gc, ec, bad, k;
    logic       fin, prd;
    logic [3:0] act;
    hw = 0; ng = 0; st = 0; rc = 0; wc = 0; gc = 0; bad = 0; fin = 1'b0; prd = 1'b1;
    ec = 0;
    addrs.delete();
    uppers.delete();
    act = pol_hi ? 4'h1 << ch : ~(4'h1 << ch);
    @(posedge clk_in);
    addr <= a; cnt <= n; ty <= t; block <= b; dly <= d; mask <= 4'h0;
    if (use_sw) sw <= 4'h1 << ch;
    else raise <= 4'h1 << ch;
    for (k = 0; k < 200 && !fin; k++) begin
      @(posedge clk_in);
      raise <= 4'h0;
      if (hold === 1'b1) sw <= 4'h0;
      #1;
      if (hold === 1'b1 && en === 1'b0 && gc == 0) hw++;
      if (en === 1'b1 && grant !== 1'b1) ng++;
      if (en === 1'b1 && (low_oe_n !== 1'b0 || mid_oe_n !== 1'b0)) bad++;
      st += (stb === 1'b1);
      rc += (rd_n === 1'b0 && mem_oe_n === 1'b0);
      wc += (wr_n === 1'b0 && mem_oe_n === 1'b0);
      gc += (gnt === act);
      ec += (en === 1'b1);
      if (rd_n === 1'b0 && prd === 1'b1) addrs.push_back({mid, low_out});
      if (data_oe_n === 1'b0) uppers.push_back(data);
      prd = rd_n;
      fin = (done === 1'b1);
    end
    if (e_hw > 0) chk("hold_wait", e_hw, hw);
    chk("early_drive", 16'h0, ng);
    chk("addr_drive", 16'h0, bad);
    chk("strobe_pulses", e_stb, st);
    chk("read_cycles", e_rd, rc);
    chk("write_cycles", e_wr, wc);
    chk("grant_seen", 16'h1, gc > 0);
    // enable spans each address-update state and three states per transfer half
    chk("enable_cycles", e_stb + 3 * (n + 1) * ((t == 2'h3) ? 2 : 1), ec);
    chk("done", 16'h1, fin);
    idle_check();
  endtask : service

  task automatic select_test();
    @(posedge clk_in);
    low_in <= 4'hA;
    repeat (4) @(posedge clk_in);
    #1 chk("register_select", 4'hA, sel);
  endtask : select_test

  task automatic mask_test();
    @(posedge clk_in);
    mask <= 4'h2;
    raise <= 4'h2;
    @(posedge clk_in);
    raise <= 4'h0;
    repeat (6) @(posedge clk_in);
    #1 chk("masked_hold", 16'h0, hold);
  endtask : mask_test

  // strobe must only move while the clock is low
  always @(stb) if (reset_n_in === 1'b1) chk("strobe_edge", 16'h0, clk_in);

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    reset_n_in = 1'b0; pol_write = 1'b0; pol_high = 1'b0; block = 1'b0; pol_hi = 1'b0;
    mask = 4'h0; sw = 4'h0; raise = 4'h0; dly = 4'h0; low_in = 4'h0;
    addr = 16'h0000; cnt = 16'h0000; ty = 2'h0;
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    idle_check();
    select_test();
    service(2'h0, 1'b0, 2'h0, 1'b0, 16'h34A7, 16'h0000, 4'h0, 1, 1, 0, 0);
    mask_test();
    service(2'h1, 1'b0, 2'h1, 1'b0, 16'h34A7, 16'h0000, 4'h3, 0, 1, 0, 1);
    service(2'h2, 1'b1, 2'h2, 1'b0, 16'h34A7, 16'h0000, 4'h0, 1, 1, 2, 0);
    chk("low_mid_addr", 8'hA7, addrs[0]);
    chk("upper_byte", 8'h34, uppers[0]);
    service(2'h3, 1'b1, 2'h3, 1'b0, 16'h34A7, 16'h0000, 4'h0, 1, 2, 2, 1);
    @(posedge clk_in);
    pol_write <= 1'b1;
    pol_high <= 1'b1;
    pol_hi <= 1'b1;
    @(posedge clk_in);
    pol_write <= 1'b0;
    idle_check();
    service(2'h0, 1'b1, 2'h2, 1'b1, 16'h12FE, 16'h0002, 4'h0, 1, 2, 6, 0);
    chk("block_transfers", 16'h3, addrs.size());
    chk("block_addrs", 16'hFF00, {addrs[1], addrs[2]});
    chk("block_first", 8'hFE, addrs[0]);
    chk("block_uppers", 16'h1213, {uppers[0], uppers[1]});
    summarize();
  end
endmodule : dbm_bus_master_test
`default_nettype wire
